// ### src/dpp_consts.svh
`ifndef DPP_CONSTS_SVH
`define DPP_CONSTS_SVH
// ----------------------------------------
// clock and time base
// ----------------------------------------
`define DPP_CLK_NS 5
`define DPP_TICK_NS 100000
`define DPP_TICKS_PER_MS 4'ha
// ----------------------------------------
// register indices (word addresses)
// ----------------------------------------
`define DPP_R_TGT 5'h00
`define DPP_R_SPDSRC 5'h01
`define DPP_R_SPDPCT 5'h02
`define DPP_R_RUP 5'h03
`define DPP_R_RDN 5'h04
`define DPP_R_ARR 5'h05
`define DPP_R_CHOLD 5'h08
`define DPP_R_SUPAMT 5'h09
`define DPP_R_SUPRATE 5'h0a
`define DPP_R_FILT 5'h0c
`define DPP_R_RATIO2 5'h0d
`define DPP_R_MEAS 5'h0e
`define DPP_R_ECLR 5'h10
`define DPP_R_GNUM 5'h11
`define DPP_R_GDEN 5'h12
`define DPP_R_MODE 5'h13
`define DPP_R_CTRL 5'h14
`define DPP_R_CRANGE 5'h15
`define DPP_R_CDET 5'h16
`define DPP_NCFG 5'h17
`define DPP_R_STATUS 5'h17
`define DPP_R_TARGET 5'h18
`define DPP_R_FBPOS 5'h19
`define DPP_R_SPEED 5'h1a
`define DPP_R_PFREQ 5'h1b
// ----------------------------------------
// fields and codes
// ----------------------------------------
`define DPP_MODE_DONE_BIT 6
`define DPP_MODE_CURVE_BIT 12
`define DPP_CTRL_START_BIT 15
`define DPP_CTRL_ECLR_BIT 14
`define DPP_CTRL_MASK 16'h0f1f
`define DPP_SRC_PULSE_TRAIN 5'h0c
`define DPP_CMODE_POS 4'h1
`define DPP_MEAS_MAIN 2'h0
`define DPP_MEAS_ENC 2'h1
`define DPP_SPD_FAST_PULSE_INPUT_B 3'h5
`define DPP_PCT_FULL 16'h03e8
`define DPP_FINE_PER_PCT 17'h00064
`define DPP_RAMP_GAIN 16'h03e8
`define DPP_CREEP 17'h00064
`define DPP_BRAKE_K 64'h00000000000007d0
`define DPP_SUP_DIV 17'h0000a
`define DPP_DIV_STEPS 6'h21
// ----------------------------------------
// reset values
// ----------------------------------------
`define DPP_RST_SPDPCT 16'h00c8
`define DPP_RST_RAMP 16'h012c
`define DPP_RST_ARR 16'h0064
`define DPP_RST_HOME_SPD 16'h00c8
`define DPP_RST_CHOLD 16'h00c8
`define DPP_RST_SUPRATE 16'h0050
`define DPP_RST_RAPO 16'h0032
`define DPP_RST_FILT 16'h0064
`define DPP_RST_RATIO 16'h03e8
`define DPP_RST_CRANGE 16'h000a
`define DPP_RST_CDET 16'h0064
`endif

// ### src/dpp_pkg.sv
package dpp_pkg;
`include "dpp_consts.svh"
typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_CALC = 5'h02,
    ST_RUN = 5'h04,
    ST_HOLD = 5'h08,
    ST_SETTLE = 5'h10
} dpp_state_t;
typedef logic [15:0] dpp_word_t;
localparam dpp_word_t [22:0] DPP_CFG_RST = {
    `DPP_RST_CDET, `DPP_RST_CRANGE, 16'h0000, 16'h0000,
    `DPP_RST_RATIO, `DPP_RST_RATIO, 16'h0000, 16'h0000,
    16'h0000, `DPP_RST_RATIO, `DPP_RST_FILT, `DPP_RST_RAPO,
    `DPP_RST_SUPRATE, 16'h0000, `DPP_RST_CHOLD, 16'h0000,
    `DPP_RST_HOME_SPD, `DPP_RST_ARR, `DPP_RST_RAMP, `DPP_RST_RAMP,
    `DPP_RST_SPDPCT, 16'h0000, 16'h0000
};
endpackage

// ### src/dpp_timer.sv
`timescale 1ns/1ps
module dpp_timer
    import dpp_pkg::*;
#(
    parameter int W = 16
) (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic load_i,
    input wire logic tick_i,
    input wire logic [W-1:0] value_i,
    output logic busy_o
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } dpp_tmr_t;
    dpp_tmr_t s;
    dpp_tmr_t n;

    always_comb begin
        n = s;
        if (load_i) begin
            n.cnt = value_i;
        end else if (tick_i && s.cnt != '0) begin
            n.cnt = s.cnt - 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign busy_o = (s.cnt != '0);
endmodule

// ### src/dpp_top.sv
`timescale 1ns/1ps
`include "dpp_consts.svh"
module dpp_top
    import dpp_pkg::*;
#(
    parameter int CYC_PER_TICK = `DPP_TICK_NS / `DPP_CLK_NS
) (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic [15:0] analog_input_one_i,
    input wire logic [15:0] analog_input_two_i,
    input wire logic [15:0] analog_input_three_i,
    input wire logic fast_pulse_input_a_i,
    input wire logic fast_pulse_input_b_i,
    input wire logic enc_step_i,
    input wire logic enc_dir_i,
    input wire logic sup_edge_term_i,
    input wire logic sup_level_term_i,
    input wire logic spindle_orient_done_i,
    output logic [16:0] speed_ref_o,
    output logic pos_busy_o,
    output logic completion_o,
    output logic spindle_done_o,
    output logic sup_pulse_o
);
    typedef struct packed {
        logic waitreq;
        logic [31:0] rdata;
        dpp_word_t [22:0] cfg;
        dpp_state_t st;
        logic busy;
        logic [6:0] sy1;
        logic [6:0] sy2;
        logic [6:0] sy3;
        logic [3:0] sub;
        logic ms;
        logic [32:0] dvd;
        logic [16:0] rem;
        logic [5:0] dcnt;
        logic [15:0] carry;
        logic [31:0] tgt;
        logic [41:0] pos_q;
        logic [16:0] spd;
        logic [15:0] racc;
        logic [31:0] fb;
        logic [31:0] spend;
        logic [16:0] sacc;
        logic spulse;
        logic [15:0] cmain;
        logic [15:0] cenc;
        logic [15:0] fx;
        logic [15:0] fy;
        logic signed [19:0] facc;
        logic done;
        logic dlatch;
        logic sdone;
    } dpp_regs_t;

    dpp_regs_t s;
    dpp_regs_t n;

    logic tk_busy;
    logic arr_busy;
    logic det_busy;
    logic ch_busy;
    logic sh_busy;
    logic tick;
    logic arr_ld;
    logic det_ld;
    logic ch_ld;
    logic sh_ld;
    logic cevt;
    logic [16:0] det_val;

    // ----------------------------------------
    // time base and hold timers
    // ----------------------------------------
    assign tick = !tk_busy;
    assign det_val = {1'b0, s.cfg[`DPP_R_CDET]} + 17'h00001;

    dpp_timer #(.W(16)) u_tick (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .load_i(!tk_busy),
        .tick_i(1'b1),
        .value_i(16'(CYC_PER_TICK - 1)),
        .busy_o(tk_busy)
    );
    dpp_timer #(.W(16)) u_arr (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .load_i(arr_ld),
        .tick_i(s.ms),
        .value_i(s.cfg[`DPP_R_ARR]),
        .busy_o(arr_busy)
    );
    dpp_timer #(.W(17)) u_det (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .load_i(det_ld),
        .tick_i(tick),
        .value_i(det_val),
        .busy_o(det_busy)
    );
    dpp_timer #(.W(16)) u_chold (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .load_i(ch_ld),
        .tick_i(s.ms),
        .value_i(s.cfg[`DPP_R_CHOLD]),
        .busy_o(ch_busy)
    );
    dpp_timer #(.W(16)) u_shold (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .load_i(sh_ld),
        .tick_i(s.ms),
        .value_i(s.cfg[`DPP_R_CHOLD]),
        .busy_o(sh_busy)
    );

    // ----------------------------------------
    // next-state logic
    // ----------------------------------------
    always_comb begin
        logic [6:0] rise;
        logic [31:0] rv;
        dpp_word_t wv;
        logic start;
        logic eclr;
        logic [15:0] den;
        logic [15:0] tacc;
        logic [15:0] tdec;
        logic [15:0] tr;
        logic [15:0] pct;
        logic [16:0] gfine;
        logic [16:0] goal;
        logic [16:0] r2;
        logic [41:0] tgt_q;
        logic [41:0] remq;
        logic brake;
        logic [31:0] d;
        logic [31:0] dev;
        logic sup_en;
        logic act;
        logic sdec;
        logic [31:0] sadd;
        logic pm;
        logic [16:0] hyb;
        logic signed [19:0] tau;
        rise = s.sy2 & ~s.sy3;
        rv = 32'h00000000;
        wv = s.cfg[avs_address_i];
        start = 1'b0;
        eclr = 1'b0;
        arr_ld = 1'b0;
        det_ld = 1'b0;
        ch_ld = 1'b0;
        sh_ld = 1'b0;
        cevt = 1'b0;
        sdec = 1'b0;
        sadd = 32'h00000000;
        d = 32'h00000000;
        dev = 32'h00000000;
        n = s;
        n.sy1 = {spindle_orient_done_i, sup_level_term_i, sup_edge_term_i,
                 enc_dir_i, enc_step_i, fast_pulse_input_b_i,
                 fast_pulse_input_a_i};
        n.sy2 = s.sy1;
        n.sy3 = s.sy2;

        // ----------------------------------------
        // register bus
        // ----------------------------------------
        if (avs_address_i < `DPP_NCFG) begin
            rv = {16'h0000, s.cfg[avs_address_i]};
        end else if (avs_address_i == `DPP_R_STATUS) begin
            rv = {24'h000000, s.spulse, s.sdone, s.done, s.st};
        end else if (avs_address_i == `DPP_R_TARGET) begin
            rv = s.tgt;
        end else if (avs_address_i == `DPP_R_FBPOS) begin
            rv = s.fb;
        end else if (avs_address_i == `DPP_R_SPEED) begin
            rv = {15'h0000, s.spd};
        end else if (avs_address_i == `DPP_R_PFREQ) begin
            rv = {16'h0000, s.fy};
        end
        n.waitreq = !((avs_read_i || avs_write_i) && s.waitreq);
        if (avs_read_i && s.waitreq) begin
            n.rdata = rv;
        end
        if (avs_byteenable_i[0]) begin
            wv[7:0] = avs_writedata_i[7:0];
        end
        if (avs_byteenable_i[1]) begin
            wv[15:8] = avs_writedata_i[15:8];
        end
        if (avs_write_i && !s.waitreq && avs_address_i < `DPP_NCFG) begin
            if (avs_address_i == `DPP_R_CTRL) begin
                n.cfg[`DPP_R_CTRL] = wv & `DPP_CTRL_MASK;
                start = avs_byteenable_i[1]
                        && avs_writedata_i[`DPP_CTRL_START_BIT];
                eclr = avs_byteenable_i[1]
                       && avs_writedata_i[`DPP_CTRL_ECLR_BIT];
            end else begin
                n.cfg[avs_address_i] = wv;
            end
        end

        // ----------------------------------------
        // ms tick
        // ----------------------------------------
        n.ms = 1'b0;
        if (tick) begin
            if (s.sub == `DPP_TICKS_PER_MS - 4'h1) begin
                n.sub = 4'h0;
                n.ms = 1'b1;
            end else begin
                n.sub = s.sub + 4'h1;
            end
        end

        // ----------------------------------------
        // pulse measure and filter
        // ----------------------------------------
        pm = (s.cfg[`DPP_R_SPDSRC][2:0] == `DPP_SPD_FAST_PULSE_INPUT_B) ? rise[1] : rise[0];
        n.cmain = s.ms ? {15'h0000, pm} : s.cmain + {15'h0000, pm};
        n.cenc = s.ms ? {15'h0000, rise[2]} : s.cenc + {15'h0000, rise[2]};
        hyb = ({1'b0, s.cmain} + {1'b0, s.cenc}) >> 1;
        if (s.ms) begin
            if (s.cfg[`DPP_R_MEAS][1:0] == `DPP_MEAS_MAIN) begin
                n.fx = s.cmain;
            end else if (s.cfg[`DPP_R_MEAS][1:0] == `DPP_MEAS_ENC) begin
                n.fx = s.cenc;
            end else begin
                n.fx = hyb[15:0];
            end
        end
        tau = $signed({4'h0, s.cfg[`DPP_R_FILT]});
        if (tau == 20'sd0) begin
            n.fy = s.fx;
            n.facc = 20'sd0;
        end else if (tick) begin
            n.facc = s.facc + $signed({4'h0, s.fx}) - $signed({4'h0, s.fy});
        end else if (s.facc >= tau) begin
            n.fy = s.fy + 16'h0001;
            n.facc = s.facc - tau;
        end else if (s.facc <= -tau) begin
            n.fy = s.fy - 16'h0001;
            n.facc = s.facc + tau;
        end

        // ----------------------------------------
        // speed goal
        // ----------------------------------------
        // speed source select
        case (s.cfg[`DPP_R_SPDSRC][2:0])
            3'h1: pct = analog_input_one_i;
            3'h2: pct = analog_input_two_i;
            3'h3: pct = analog_input_three_i;
            3'h4, 3'h5: pct = s.fy;
            default: pct = s.cfg[`DPP_R_SPDPCT];
        endcase
        if (pct > `DPP_PCT_FULL) begin
            pct = `DPP_PCT_FULL;
        end
        gfine = 17'(pct) * `DPP_FINE_PER_PCT;
        tacc = (s.cfg[`DPP_R_RUP] == 16'h0000) ? 16'h0001 : s.cfg[`DPP_R_RUP];
        tdec = (s.cfg[`DPP_R_RDN] == 16'h0000) ? 16'h0001 : s.cfg[`DPP_R_RDN];
        den = (s.cfg[`DPP_R_GDEN] == 16'h0000) ? 16'h0001 : s.cfg[`DPP_R_GDEN];
        tgt_q = {s.tgt, 10'h000};
        remq = tgt_q - s.pos_q;
        brake = (64'(remq) * `DPP_BRAKE_K)
                <= (64'(s.spd) * 64'(s.spd) * 64'(tdec));
        goal = brake ? `DPP_CREEP
               : ((gfine < `DPP_CREEP) ? `DPP_CREEP : gfine);
        tr = (goal < s.spd) ? tdec : tacc;
        r2 = {s.rem[15:0], s.dvd[32]};

        // ----------------------------------------
        // positioning sequence
        // ----------------------------------------
        case (s.st)
            ST_IDLE: begin
                if (start) begin
                    n.dvd = {1'b0, 32'(s.cfg[`DPP_R_TGT])
                            * 32'(s.cfg[`DPP_R_GNUM])}
                            + {17'h00000, s.carry};
                    n.rem = 17'h00000;
                    n.dcnt = `DPP_DIV_STEPS;
                    n.dlatch = 1'b0;
                    n.st = ST_CALC;
                end
            end
            ST_CALC: begin
                if (s.dcnt != 6'h00) begin
                    n.dcnt = s.dcnt - 6'h01;
                    if (r2 >= {1'b0, den}) begin
                        n.rem = r2 - {1'b0, den};
                        n.dvd = {s.dvd[31:0], 1'b1};
                    end else begin
                        n.rem = r2;
                        n.dvd = {s.dvd[31:0], 1'b0};
                    end
                end else begin
                    n.tgt = s.pos_q[41:10] + s.dvd[31:0];
                    n.carry = s.rem[15:0];
                    n.racc = 16'h0000;
                    n.st = ST_RUN;
                end
            end
            ST_RUN: begin
                if (s.pos_q >= tgt_q) begin
                    n.pos_q = tgt_q;
                    n.spd = 17'h00000;
                    arr_ld = 1'b1;
                    n.st = ST_HOLD;
                end else if (tick) begin
                    n.racc = s.racc + `DPP_RAMP_GAIN;
                    n.pos_q = s.pos_q + {25'h0000000, s.spd};
                end else if (s.racc >= tr) begin
                    n.racc = s.racc - tr;
                    if (s.spd < goal) begin
                        n.spd = s.spd + 17'h00001;
                    end else if (s.spd > goal) begin
                        n.spd = s.spd - 17'h00001;
                    end else begin
                        n.racc = 16'h0000;
                    end
                end
            end
            ST_HOLD: begin
                if (!arr_busy) begin
                    det_ld = 1'b1;
                    n.st = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                d = s.tgt - s.fb;
                dev = d[31] ? (32'h00000000 - d) : d;
                if (dev >= {16'h0000, s.cfg[`DPP_R_CRANGE]}) begin
                    det_ld = 1'b1;
                end else if (!det_busy) begin
                    cevt = 1'b1;
                    n.st = ST_IDLE;
                end
            end
            default: begin
                n.st = ST_IDLE;
            end
        endcase
        n.busy = (n.st != ST_IDLE);

        // ----------------------------------------
        // completion outputs
        // ----------------------------------------
        // load hold time
        ch_ld = cevt;
        if (cevt) begin
            n.dlatch = 1'b1;
        end
        if (s.cfg[`DPP_R_MODE][`DPP_MODE_DONE_BIT]) begin
            n.done = s.dlatch || cevt;
        end else begin
            n.done = cevt || ch_busy;
        end
        sh_ld = rise[6];
        n.sdone = rise[6] || sh_busy;

        // ----------------------------------------
        // encoder feedback
        // ----------------------------------------
        if (eclr) begin
            n.fb = {16'h0000, s.cfg[`DPP_R_ECLR]};
        end else if (rise[2]) begin
            n.fb = s.sy2[3] ? s.fb - 32'h00000001 : s.fb + 32'h00000001;
        end

        // ----------------------------------------
        // pulse superposition
        // ----------------------------------------
        // enable condition
        sup_en = (s.cfg[`DPP_R_CTRL][4:0] == `DPP_SRC_PULSE_TRAIN)
                 || (s.cfg[`DPP_R_CTRL][11:8] == `DPP_CMODE_POS);
        if (sup_en && rise[4]) begin
            sadd = {16'h0000, s.cfg[`DPP_R_SUPAMT]};
        end
        act = sup_en && (s.sy2[5] || s.spend != 32'h00000000);
        n.spulse = 1'b0;
        if (act && s.ms) begin
            n.sacc = s.sacc + {1'b0, s.cfg[`DPP_R_SUPRATE]};
        end else if (act && s.sacc >= `DPP_SUP_DIV) begin
            n.sacc = s.sacc - `DPP_SUP_DIV;
            n.spulse = 1'b1;
            sdec = (s.spend != 32'h00000000);
        end
        n.spend = s.spend + sadd - {31'h00000000, sdec};
        if (!sup_en) begin
            n.spend = 32'h00000000;
            n.sacc = 17'h00000;
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s <= '0;
            s.waitreq <= 1'b1;
            s.cfg <= DPP_CFG_RST;
            s.st <= ST_IDLE;
        end else begin
            s <= n;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign avs_readdata_o = s.rdata;
    assign avs_waitrequest_o = s.waitreq;
    assign speed_ref_o = s.spd;
    assign pos_busy_o = s.busy;
    assign completion_o = s.done;
    assign spindle_done_o = s.sdone;
    assign sup_pulse_o = s.spulse;
endmodule

// ### test/dpp_chk.sv
`timescale 1ns/1ps
module dpp_chk (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic spindle_orient_done_i,
    input wire logic [16:0] speed_ref_o,
    input wire logic pos_busy_o,
    input wire logic completion_o,
    input wire logic spindle_done_o,
    input wire logic sup_pulse_o
);
default clocking cb @(posedge core_clk_i);
endclocking
default disable iff (!rstn_i);
a_bus_answer: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("bus answer missing");
a_wait_single: assert property (
    $fell(avs_waitrequest_o) |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
a_upper_zero: assert property (
    avs_read_i && !avs_waitrequest_o && avs_address_i < 5'h17
    |-> avs_readdata_o[31:16] == 16'h0000)
    else $error("upper read bits set");
a_speed_limit: assert property (
    speed_ref_o <= 17'h186a0)
    else $error("speed above maximum");
a_idle_speed: assert property (
    !pos_busy_o && !$past(pos_busy_o) |-> $stable(speed_ref_o))
    else $error("speed moved while idle");
a_start_busy: assert property (
    avs_write_i && !avs_waitrequest_o && avs_address_i == 5'h14 &&
    avs_writedata_i[15] && avs_byteenable_i[1] && !pos_busy_o
    |-> ##[1:3] pos_busy_o)
    else $error("start not taken");
a_done_after: assert property (
    $fell(pos_busy_o) |-> ##[0:2] completion_o)
    else $error("completion missing");
a_spindle_done: assert property (
    $rose(spindle_orient_done_i) |-> ##[1:8] spindle_done_o)
    else $error("spindle completion missing");
c_move: cover property ($fell(pos_busy_o));
c_done: cover property ($rose(completion_o));
c_sup: cover property (sup_pulse_o);
endmodule
bind dpp_top dpp_chk u_chk (.*);

// ### test/dpp_motor.sv
`timescale 1ns/1ps
module dpp_motor (
    input wire logic core_clk_i,
    input wire logic pulse_en_i,
    input wire logic [16:0] speed_ref_i,
    output logic pulse_a_o,
    output logic pulse_b_o,
    output logic step_o,
    output logic dir_o
);
logic [7:0] div = 8'h00;
// pulse sources gated by pulse_en_i, encoder stepping at a fixed rate while the speed reference is nonzero
always @(posedge core_clk_i) begin
    div <= div + 8'h01;
    pulse_a_o <= pulse_en_i && div[3];
    pulse_b_o <= pulse_en_i && div[4];
    step_o <= (speed_ref_i != 17'h00000) && div[7];
    dir_o <= 1'b0;
end
endmodule

// ### test/test_digital_positioning_profile.sv
`timescale 1ns/1ps
module test_digital_positioning_profile;
logic core_clk_i = 0, rstn_i = 0, avs_read_i = 0, avs_write_i = 0;
logic [4:0] avs_address_i = 0;
logic [31:0] avs_writedata_i = 0, avs_readdata_o, q;
logic [3:0] avs_byteenable_i = 4'h3;
logic [15:0] analog_input_one_i = 16'h0064, analog_input_two_i = 0;
logic [15:0] analog_input_three_i = 0;
logic fast_pulse_input_a_i, fast_pulse_input_b_i, enc_step_i, enc_dir_i;
logic sup_edge_term_i = 0, sup_level_term_i = 0, spindle_orient_done_i = 0;
logic [16:0] speed_ref_o;
logic avs_waitrequest_o, pos_busy_o, completion_o, spindle_done_o;
logic sup_pulse_o, pen = 0;
int err_total = 0, comparisons = 0, scnt = 0, n, i;
logic [4:0] ri [7] = '{5'h02, 5'h03, 5'h04, 5'h05, 5'h08, 5'h0c, 5'h0d};
logic [15:0] rv [7] = '{16'h00c8, 16'h012c, 16'h012c, 16'h0064,
    16'h00c8, 16'h0064, 16'h03e8};
dpp_top #(.CYC_PER_TICK(20)) DUT (.*);
dpp_motor u_motor (
    .core_clk_i(core_clk_i),
    .pulse_en_i(pen),
    .speed_ref_i(speed_ref_o),
    .pulse_a_o(fast_pulse_input_a_i),
    .pulse_b_o(fast_pulse_input_b_i),
    .step_o(enc_step_i),
    .dir_o(enc_dir_i)
);
always #2.5 core_clk_i = ~core_clk_i;
always @(posedge core_clk_i) if (sup_pulse_o === 1'b1) scnt <= scnt + 1;
task automatic finish_test;
    if (err_total == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
endtask
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
        err_total++;
        $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
endtask
task automatic lim(input int k, input int b);
    if (k >= b) begin
        err_total++;
        finish_test();
    end
endtask
task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d,
    input logic [3:0] be, output logic [31:0] r);
    int k;
    k = 0;
    @(posedge core_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= {16'h0000, d};
    avs_byteenable_i <= be;
    avs_write_i <= w;
    avs_read_i <= !w;
    do begin
        @(posedge core_clk_i);
        k++;
    end while (avs_waitrequest_o !== 1'b0 && k < 50);
    r = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    lim(k, 50);
endtask
task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, 4'h3, r);
endtask
task automatic rd(input logic [4:0] a, input logic [15:0] e);
    logic [31:0] r;
    bus(1'b0, a, 16'h0000, 4'h3, r);
    chk(r, {16'h0000, e});
endtask
task automatic wt(input int s, input logic v);
    int k;
    k = 0;
    while ((s ? completion_o : pos_busy_o) !== v && k < 40000) begin
        @(posedge core_clk_i);
        k++;
    end
    lim(k, 40000);
endtask
task automatic pulse_edge;
    @(posedge core_clk_i);
    sup_edge_term_i <= 1'b1;
    repeat (8) @(posedge core_clk_i);
    sup_edge_term_i <= 1'b0;
    repeat (3000) @(posedge core_clk_i);
endtask
initial begin
    repeat (5) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    for (i = 0; i < 7; i++) rd(ri[i], rv[i]);
    rd(5'h1c, 16'h0000);
    wr(5'h1c, 16'h1234);
    rd(5'h1c, 16'h0000);
    for (i = 0; i < 6; i++) begin
        wr(5'h01, i[15:0]);
        rd(5'h01, i[15:0]);
    end
    for (i = 0; i < 3; i++) begin
        wr(5'h0e, i[15:0]);
        rd(5'h0e, i[15:0]);
    end
    wr(5'h00, 16'hffff);
    rd(5'h00, 16'hffff);
    bus(1'b1, 5'h00, 16'h1201, 4'h1, q);
    rd(5'h00, 16'hff01);
    wr(5'h13, 16'h1000);
    rd(5'h13, 16'h1000);
    wr(5'h13, 16'h0000);
    wr(5'h11, 16'h0003);
    wr(5'h12, 16'h0002);
    wr(5'h00, 16'h0001);
    wr(5'h03, 16'h0001);
    wr(5'h04, 16'h0001);
    wr(5'h05, 16'h0001);
    wr(5'h08, 16'h0002);
    wr(5'h14, 16'h8000);
    wt(0, 1'b1);
    repeat (200) @(posedge core_clk_i);
    chk(speed_ref_o, 17'h00064);
    wr(5'h14, 16'h8000);
    wt(0, 1'b0);
    chk(speed_ref_o, 17'h00000);
    rd(5'h18, 16'h0001);
    wt(1, 1'b1);
    n = 0;
    while (completion_o === 1'b1 && n < 2000) begin
        @(posedge core_clk_i);
        n++;
    end
    chk(n > 180 && n < 420, 1'b1);
    wr(5'h10, 16'h0002);
    wr(5'h14, 16'h4000);
    rd(5'h19, 16'h0002);
    wr(5'h13, 16'h0040);
    wr(5'h14, 16'h8000);
    wt(0, 1'b1);
    wt(0, 1'b0);
    rd(5'h18, 16'h0003);
    wt(1, 1'b1);
    repeat (1000) @(posedge core_clk_i);
    chk(completion_o, 1'b1);
    wr(5'h09, 16'h0005);
    wr(5'h14, 16'h000c);
    pulse_edge();
    chk(scnt, 5);
    wr(5'h14, 16'h0100);
    pulse_edge();
    chk(scnt, 10);
    wr(5'h14, 16'h0000);
    pulse_edge();
    chk(scnt, 10);
    wr(5'h0a, 16'h0005);
    wr(5'h14, 16'h000c);
    n = scnt;
    sup_level_term_i <= 1'b1;
    repeat (2000) @(posedge core_clk_i);
    sup_level_term_i <= 1'b0;
    repeat (50) @(posedge core_clk_i);
    chk(scnt - n > 3 && scnt - n < 7, 1'b1);
    pen <= 1'b1;
    spindle_orient_done_i <= 1'b1;
    repeat (10) @(posedge core_clk_i);
    chk(spindle_done_o, 1'b1);
    wr(5'h0e, 16'h0000);
    wr(5'h0c, 16'h0000);
    repeat (600) @(posedge core_clk_i);
    bus(1'b0, 5'h1b, 16'h0000, 4'h3, q);
    chk(q >= 6 && q <= 7, 1'b1);
    finish_test();
end
endmodule
